// >>> mbrd_crc16.sv
// Byte-wide CRC-16 accumulator
`timescale 1ns/100ps
module mbrd_crc16
    import mbrd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        clear,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);

    logic [15:0] next_crc;

    always_comb begin
        next_crc = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            if (next_crc[0]) begin
                next_crc = (next_crc >> 1) ^ CRC_POLY_REV;
            end else begin
                next_crc = next_crc >> 1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || clear) begin
            crc <= CRC_INIT;
        end else if (en) begin
            crc <= next_crc;
        end
    end

endmodule

// >>> mbrd_hreg_mem.sv
// Holding register store with registered read data
`timescale 1ns/100ps
module mbrd_hreg_mem #(
    parameter int AW    = 8,
    parameter int DEPTH = 256
) (
    input  wire logic          core_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [15:0]   wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [15:0]   rd_data
);

    logic [15:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule

// >>> mbrd_master_model.sv
// Serial-bus master model facing the read command block
`timescale 1ns/100ps
module mbrd_master_model (
    input  wire logic       core_clk,
    input  wire logic       slow,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_end,
    output logic            rx_error,
    output logic            tx_ready
);
    initial begin
        {rx_data, rx_valid, rx_end, rx_error, tx_ready} = 12'h001;
    end
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction
    // Slow mode stalls the transmitter at random
    always @(posedge core_clk) begin
        tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
    end
    task automatic send(input logic [47:0] q, input logic bad, input logic err);
        logic [15:0] c;
        logic [7:0]  b;
        c = 16'hFFFF;
        for (int i = 0; i < 8; i++) begin
            b = i < 6 ? q[47-8*i -: 8] : i == 6 ? c[7:0] ^ {7'h00, bad} : c[15:8];
            if (i < 6) c = crc_step(c, b);
            @(posedge core_clk);
            rx_data <= b;
            rx_valid <= 1'b1;
            rx_error <= err && i == 3;
        end
        @(posedge core_clk);
        {rx_valid, rx_error, rx_end} <= 3'h1;
        rx_data <= ~b;
        @(posedge core_clk);
        rx_end <= 1'b0;
    endtask
endmodule

// >>> mbrd_pkg.sv
// Shared constants for the serial-bus read command block
package mbrd_pkg;

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0]  WB_OFS_SLAVE_ADDR = 8'h00;
    localparam logic [7:0]  WB_OFS_STATUS     = 8'h04;
    localparam logic [7:0]  WB_OFS_MEM_INDEX  = 8'h08;
    localparam logic [7:0]  WB_OFS_MEM_DATA   = 8'h0C;
    localparam logic [7:0]  SLAVE_ADDR_RESET  = 8'h01;
    localparam logic [7:0]  SLAVE_ADDR_MIN    = 8'h01;
    localparam logic [7:0]  SLAVE_ADDR_MAX    = 8'hF7;

    // Function and exception codes
    localparam logic [7:0]  FUNC_READ_COILS   = 8'h01;
    localparam logic [7:0]  FUNC_READ_REGS    = 8'h03;
    localparam logic [7:0]  EXC_FUNC_FLAG     = 8'h80;
    localparam logic [7:0]  EXC_BAD_VALUE     = 8'h03;

    // Frame layout
    localparam logic [3:0]  QUERY_LEN         = 4'h8;
    localparam logic [3:0]  RX_OVERFLOW       = 4'h9;
    localparam logic [5:0]  HDR_LEN           = 6'h03;
    localparam logic [15:0] MAX_COILS         = 16'h0020;
    localparam logic [15:0] MAX_REGS          = 16'h0010;

    // CRC-16, x^16+x^15+x^2+1, bit-reversed form
    localparam logic [15:0] CRC_POLY_REV      = 16'hA001;
    localparam logic [15:0] CRC_INIT          = 16'hFFFF;
    localparam logic [15:0] CRC_RESIDUE       = 16'h0000;

    // Coil map and packed status words
    localparam int          COIL_TOP          = 88;
    localparam int          COIL_EXT_W        = 128;
    localparam int          STATUS_COIL_BASE  = 16;
    localparam logic [16:0] PACKED_REG_FIRST  = 17'h01E01;
    localparam logic [16:0] PACKED_REG_LAST   = 17'h01E05;

    // Bit positions in the first packed status word
    localparam int BIT_POWER_ON_TIME_OVER  = 15;
    localparam int BIT_OPERATION_TIME_OVER = 14;
    localparam int BIT_TORQUE_LIMITED      = 13;
    localparam int BIT_SUPPLY_VOLTAGE_LOW  = 12;
    localparam int BIT_TORQUE_OUT_OF_BAND  = 10;
    localparam int BIT_SET_FREQ_REACHED    = 9;
    localparam int BIT_PID_OVER_DEVIATION  = 7;
    localparam int BIT_OVERLOAD_NOTICE     = 6;
    localparam int BIT_SET_FREQ_OVERREACH  = 5;
    localparam int BIT_CONST_FREQ_REACHED  = 4;
    localparam int BIT_RUNNING             = 3;
    localparam int BIT_DRIVE_READY         = 1;
    localparam int BIT_DIR_REVERSE         = 0;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_RECV  = 6'h02,
        ST_CHECK = 6'h04,
        ST_FETCH = 6'h08,
        ST_EMIT  = 6'h10,
        ST_WAIT  = 6'h20
    } mbrd_state_t;

endpackage

// >>> mbrd_reader.sv
// Read coil status and read holding register command handler
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module mbrd_reader
    import mbrd_pkg::*;
#(
    parameter int HREG_AW    = 8,
    parameter int HREG_DEPTH = 256
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Received bytes from the line receiver
    input  wire logic [7:0]          rx_data,
    input  wire logic                rx_valid,
    input  wire logic                rx_end,
    input  wire logic                rx_error,
    // Response bytes to the line transmitter
    output logic      [7:0]          tx_data,
    output logic                     tx_valid,
    output logic                     tx_last,
    input  wire logic                tx_ready,
    output logic                     busy,
    // Coil states, coil n on bit n-1
    input  wire logic [COIL_TOP-1:0] coil_state,
    // Drive status flags
    input  wire logic                power_on_time_over,
    input  wire logic                operation_time_over,
    input  wire logic                torque_limited,
    input  wire logic                supply_voltage_low,
    input  wire logic                torque_out_of_band,
    input  wire logic                set_freq_reached,
    input  wire logic                pid_over_deviation,
    input  wire logic                overload_notice,
    input  wire logic                set_freq_overreached,
    input  wire logic                const_freq_reached,
    input  wire logic                running,
    input  wire logic                drive_ready,
    input  wire logic                dir_reverse
);

    ////////////////////////////////////////////////////////////////////////
    mbrd_state_t            state;
    logic [7:0]             slave_addr;
    logic [HREG_AW-1:0]     mem_index;
    logic [15:0]            frame_count;
    logic [7:0]             last_exc;
    logic [7:0]             rx_buf [QUERY_LEN];
    logic [3:0]             rx_cnt;
    logic                   rx_bad;
    logic [15:0]            rx_crc;
    logic [15:0]            tx_crc;
    logic [7:0]             q_func;
    logic [15:0]            q_start;
    logic [15:0]            q_count;
    logic                   q_exc;
    logic [7:0]             q_field;
    logic [5:0]             body_len;
    logic [5:0]             k;
    logic [15:0]            mem_rdata;
    logic                   mem_wr;
    logic [15:0]            q_start_rx;
    logic [15:0]            q_count_rx;
    logic                   frame_ok;
    logic                   coil_cnt_bad;
    logic                   reg_cnt_bad;
    logic [5:0]             coil_bytes;
    logic [15:0]            status_word;
    logic [COIL_EXT_W-1:0]  coil_ext;
    logic [5:0]             data_idx;
    logic [7:0]             coil_byte;
    logic [16:0]            reg_idx;
    logic [16:0]            reg_num;
    logic [2:0]             packed_sel;
    logic [15:0]            reg_word;
    logic [7:0]             next_tx_data;
    logic                   rx_take;

    ////////////////////////////////////////////////////////////////////////
    // Coil image and packed status word
    always_comb begin
        status_word                          = 16'h0000;
        status_word[BIT_POWER_ON_TIME_OVER]  = power_on_time_over;
        status_word[BIT_OPERATION_TIME_OVER] = operation_time_over;
        status_word[BIT_TORQUE_LIMITED]      = torque_limited;
        status_word[BIT_SUPPLY_VOLTAGE_LOW]  = supply_voltage_low;
        status_word[BIT_TORQUE_OUT_OF_BAND]  = torque_out_of_band;
        status_word[BIT_SET_FREQ_REACHED]    = set_freq_reached;
        status_word[BIT_PID_OVER_DEVIATION]  = pid_over_deviation;
        status_word[BIT_OVERLOAD_NOTICE]     = overload_notice;
        status_word[BIT_SET_FREQ_OVERREACH]  = set_freq_overreached;
        status_word[BIT_CONST_FREQ_REACHED]  = const_freq_reached;
        status_word[BIT_RUNNING]             = running;
        status_word[BIT_DRIVE_READY]         = drive_ready;
        status_word[BIT_DIR_REVERSE]         = dir_reverse;
        // Bit n is coil n, except bits 16 to 31 which hold the status word; bit 0 and all above the top coil stay zero
        coil_ext = '0;
        coil_ext[COIL_TOP:1] = coil_state;
        coil_ext[STATUS_COIL_BASE +: 16] = status_word;
    end

    ////////////////////////////////////////////////////////////////////////
    // Response data selection
    assign data_idx = k - HDR_LEN;
    assign reg_idx  = 17'(q_start) + 17'(data_idx[5:1]);
    assign reg_num  = reg_idx + 17'h00001;
    assign packed_sel = 3'(reg_num - PACKED_REG_FIRST);

    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_coil_bit
            logic [16:0] num;
            logic [16:0] pos;
            assign pos = 17'({data_idx[1:0], 3'(b)});
            // Coil number is start field plus one plus offset
            assign num = 17'(q_start) + pos + 17'h00001;
            // Bit b of byte j is offset 8j+b, lowest byte first
            assign coil_byte[b] = (pos < 17'(q_count)) && (num < 17'(COIL_EXT_W)) &&
                                  coil_ext[num[6:0]];
        end
    endgenerate

    always_comb begin
        reg_word = 16'h0000;
        if (reg_num >= PACKED_REG_FIRST && reg_num <= PACKED_REG_LAST) begin
            reg_word = coil_ext[STATUS_COIL_BASE + 16 * int'(packed_sel) +: 16];
        end else if (reg_idx < 17'(HREG_DEPTH)) begin
            reg_word = mem_rdata;
        end
    end

    always_comb begin
        next_tx_data = tx_crc[15:8];
        if (k == 6'h00) begin
            next_tx_data = slave_addr;
        end else if (k == 6'h01) begin
            next_tx_data = q_exc ? (q_func | EXC_FUNC_FLAG) : q_func;
        end else if (k == 6'h02) begin
            next_tx_data = q_field;
        end else if (k < body_len) begin
            if (q_func == FUNC_READ_COILS) begin
                next_tx_data = coil_byte;
            end else begin
                next_tx_data = data_idx[0] ? reg_word[7:0] : reg_word[15:8];
            end
        end else if (k == body_len) begin
            next_tx_data = tx_crc[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Query checks
    assign q_start_rx   = {rx_buf[2], rx_buf[3]};
    assign q_count_rx   = {rx_buf[4], rx_buf[5]};
    assign coil_cnt_bad = (q_count_rx == 16'h0000) || (q_count_rx > MAX_COILS);
    assign reg_cnt_bad  = (q_count_rx == 16'h0000) || (q_count_rx > MAX_REGS);
    assign coil_bytes   = 6'((q_count_rx + 16'h0007) >> 3);
    // Broadcast addresses never equal a valid own address
    assign frame_ok = !rx_bad && (rx_cnt == QUERY_LEN) && (rx_crc == CRC_RESIDUE) &&
                      (slave_addr >= SLAVE_ADDR_MIN) && (slave_addr <= SLAVE_ADDR_MAX) &&
                      (rx_buf[0] == slave_addr) &&
                      (rx_buf[1] == FUNC_READ_COILS || rx_buf[1] == FUNC_READ_REGS);

    assign rx_take = rx_valid && (state == ST_IDLE || state == ST_RECV);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (rx_end) begin
                        state <= ST_CHECK;
                    end else if (rx_valid || rx_error) begin
                        state <= ST_RECV;
                    end
                end
                ST_RECV: begin
                    if (rx_end) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    state <= frame_ok ? ST_FETCH : ST_IDLE;
                end
                ST_FETCH: state <= ST_EMIT;
                ST_EMIT:  state <= ST_WAIT;
                ST_WAIT: begin
                    if (tx_ready) begin
                        state <= tx_last ? ST_IDLE : ST_FETCH;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Receive buffer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_cnt <= 4'h0;
            rx_bad <= 1'b0;
            for (int i = 0; i < int'(QUERY_LEN); i++) begin
                rx_buf[i] <= 8'h00;
            end
        end else if (state == ST_CHECK) begin
            rx_cnt <= 4'h0;
            rx_bad <= 1'b0;
        end else if (state == ST_IDLE || state == ST_RECV) begin
            if (rx_error) begin
                rx_bad <= 1'b1;
            end
            if (rx_valid && rx_cnt < QUERY_LEN) begin
                rx_buf[rx_cnt[2:0]] <= rx_data;
                rx_cnt              <= rx_cnt + 4'h1;
            end else if (rx_valid) begin
                rx_cnt <= RX_OVERFLOW;
            end
        end
    end

    // Response descriptor, latched once per accepted query
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q_func   <= 8'h00;
            q_start  <= 16'h0000;
            q_count  <= 16'h0000;
            q_exc    <= 1'b0;
            q_field  <= 8'h00;
            body_len <= 6'h00;
            last_exc <= 8'h00;
        end else if (state == ST_CHECK && frame_ok) begin
            q_func  <= rx_buf[1];
            q_start <= q_start_rx;
            q_count <= q_count_rx;
            if ((rx_buf[1] == FUNC_READ_COILS && coil_cnt_bad) ||
                (rx_buf[1] == FUNC_READ_REGS && reg_cnt_bad)) begin
                q_exc    <= 1'b1;
                q_field  <= EXC_BAD_VALUE;
                last_exc <= EXC_BAD_VALUE;
                body_len <= HDR_LEN;
            end else if (rx_buf[1] == FUNC_READ_COILS) begin
                q_exc    <= 1'b0;
                q_field  <= 8'(coil_bytes);
                body_len <= HDR_LEN + coil_bytes;
            end else begin
                q_exc    <= 1'b0;
                q_field  <= 8'({q_count_rx[4:0], 1'b0});
                body_len <= HDR_LEN + 6'({q_count_rx[4:0], 1'b0});
            end
        end
    end

    // Transmit byte handshake
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_data  <= 8'h00;
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            k        <= 6'h00;
        end else if (state == ST_CHECK) begin
            k <= 6'h00;
        end else if (state == ST_EMIT) begin
            tx_data  <= next_tx_data;
            tx_valid <= 1'b1;
            tx_last  <= (k == body_len + 6'h01);
        end else if (state == ST_WAIT && tx_ready) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            k        <= k + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            busy        <= 1'b0;
            frame_count <= 16'h0000;
        end else begin
            busy <= (state == ST_CHECK && frame_ok) || state == ST_FETCH || state == ST_EMIT ||
                    (state == ST_WAIT && !(tx_ready && tx_last));
            if (state == ST_WAIT && tx_ready && tx_last) begin
                frame_count <= frame_count + 16'h0001;
            end
        end
    end

    mbrd_crc16 u_rx_crc (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clear    (!(state == ST_IDLE || state == ST_RECV)),
        .en       (rx_take),
        .data     (rx_data),
        .crc      (rx_crc)
    );

    mbrd_crc16 u_tx_crc (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clear    (state == ST_CHECK),
        .en       (state == ST_EMIT && k < body_len),
        .data     (next_tx_data),
        .crc      (tx_crc)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wishbone register file
    assign mem_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                    (wb_adr_i == WB_OFS_MEM_DATA) && (wb_sel_i[1:0] == 2'h3);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
            slave_addr <= SLAVE_ADDR_RESET;
            mem_index  <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h00000000;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                if (wb_we_i) begin
                    if (wb_adr_i == WB_OFS_SLAVE_ADDR && wb_sel_i[0]) begin
                        slave_addr <= wb_dat_i[7:0];
                    end
                    if (wb_adr_i == WB_OFS_MEM_INDEX && wb_sel_i[0]) begin
                        mem_index <= wb_dat_i[HREG_AW-1:0];
                    end
                end else begin
                    case (wb_adr_i)
                        WB_OFS_SLAVE_ADDR: wb_dat_o <= {24'h000000, slave_addr};
                        WB_OFS_STATUS:     wb_dat_o <= {frame_count, last_exc, 7'h00, busy};
                        WB_OFS_MEM_INDEX:  wb_dat_o <= 32'(mem_index);
                        default:           wb_dat_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    mbrd_hreg_mem #(
        .AW    (HREG_AW),
        .DEPTH (HREG_DEPTH)
    ) u_hreg_mem (
        .core_clk (core_clk),
        .wr_en    (mem_wr),
        .wr_addr  (mem_index),
        .wr_data  (wb_dat_i[15:0]),
        .rd_addr  (reg_idx[HREG_AW-1:0]),
        .rd_data  (mem_rdata)
    );

endmodule

// >>> mbrd_reader_chk.sv
// Port checker for the read command block
`timescale 1ns/100ps
module mbrd_reader_chk (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        rx_end,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_last,
    input wire logic        tx_ready,
    input wire logic        busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_tx_hold: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("tx byte changed before taken");
    a_last_valid: assert property (tx_last |-> tx_valid)
        else $error("last without valid");
    a_byte_gap: assert property (tx_valid && tx_ready |=> !tx_valid ##1 !tx_valid)
        else $error("tx gap too short");
    a_busy_tx: assert property (tx_valid |-> busy)
        else $error("tx while not busy");
    a_reply_lat: assert property (!busy && rx_end |=> !tx_valid [*2])
        else $error("reply too soon");
    c_last: cover property (tx_valid && tx_ready && tx_last);
    c_stall: cover property (tx_valid && !tx_ready);
    c_ack: cover property (wb_ack_o);
endmodule
bind mbrd_reader mbrd_reader_chk mbrd_reader_chk_i (.core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .rx_end, .tx_data, .tx_valid, .tx_last, .tx_ready, .busy);

// >>> tb_top.sv
// Self-checking bench for the read command block
`timescale 1ns/100ps
module tb_top
    import mbrd_pkg::*;
;
    logic        core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
    logic        rx_valid, rx_end, rx_error, tx_valid, tx_last, tx_ready, busy;
    logic [7:0]  wb_adr_i, rx_data, tx_data;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i;
    logic [15:0] flags, crc, hreg [4];
    logic [87:0] coil_state;
    logic [8:0]  exp_q [$];
    int          fails, total_checks;
    mbrd_reader mbrd_reader_i (.core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .rx_data, .rx_valid, .rx_end, .rx_error, .tx_data, .tx_valid,
        .tx_last, .tx_ready, .busy, .coil_state, .power_on_time_over(flags[15]),
        .operation_time_over(flags[14]), .torque_limited(flags[13]), .supply_voltage_low(flags[12]),
        .torque_out_of_band(flags[10]), .set_freq_reached(flags[9]), .pid_over_deviation(flags[7]),
        .overload_notice(flags[6]), .set_freq_overreached(flags[5]), .const_freq_reached(flags[4]),
        .running(flags[3]), .drive_ready(flags[1]), .dir_reverse(flags[0]));
    mbrd_master_model mbrd_master_model_i (.core_clk, .slow, .rx_data, .rx_valid, .rx_end, .rx_error, .tx_ready);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] v);
        total_checks++;
        if (v !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, v);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        for (int i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        check("wb ack", 32'h1, 32'(wb_ack_o));
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    function automatic logic coil(input int c);
        logic [15:0] sw;
        sw = flags & 16'hF6FB;
        if (c >= 16 && c <= 31) return sw[c-16];
        return c >= 1 && c <= 88 ? coil_state[c-1] : 1'b0;
    endfunction
    function automatic logic [15:0] reg_val(input int r);
        logic [15:0] w;
        if (r <= 4) return hreg[r-1];
        for (int i = 0; i < 16; i++) w[i] = coil(16 + 16 * (r - 32'h1E01) + i);
        return w;
    endfunction
    task automatic put(input logic [7:0] b, input logic last = 1'b0);
        crc = mbrd_master_model_i.crc_step(crc, b);
        exp_q.push_back({last, b});
    endtask
    task automatic settle;
        for (int i = 0; i < 400 && (exp_q.size() > 0 || busy !== 1'b0); i++) @(posedge core_clk);
        if (exp_q.size() > 0 || busy !== 1'b0) begin
            fails++;
            $display("wrong value reply bytes left expected 0 seen %0d", exp_q.size());
            exp_q.delete();
        end
        repeat (8) @(posedge core_clk);
    endtask
    task automatic ask(input logic [7:0] f, input logic [15:0] s, input logic [15:0] n);
        logic [7:0]  b;
        logic [15:0] c;
        crc = 16'hFFFF;
        put(8'h05);
        if (n == 0 || n > (f == 8'h01 ? 32 : 16)) begin
            put(f | 8'h80);
            put(8'h03);
        end else if (f == 8'h01) begin
            put(f);
            put(8'((n + 7) / 8));
            for (int i = 0; i < (n + 7) / 8; i++) begin
                for (int j = 0; j < 8; j++) b[j] = 8 * i + j < n && coil(s + 1 + 8 * i + j);
                put(b);
            end
        end else begin
            put(f);
            put(8'(2 * n));
            for (int i = 0; i < n; i++) begin
                put(8'(reg_val(s + 1 + i) >> 8));
                put(8'(reg_val(s + 1 + i)));
            end
        end
        c = crc;
        put(c[7:0]);
        put(c[15:8], 1'b1);
        mbrd_master_model_i.send({8'h05, f, s, n}, 1'b0, 1'b0);
        settle;
    endtask
    always @(posedge core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            check("tx byte", exp_q.size() ? 32'(exp_q.pop_front()) : 32'hDEAD,
                  32'({tx_last, tx_data}));
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        wrap_up;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, slow, rstn, wb_adr_i, wb_dat_i, wb_sel_i} = 49'hF;
        {fails, total_checks} = 64'h0;
        rd = $urandom(32'h8D2779E6);
        coil_state = 88'({$urandom, $urandom, $urandom});
        flags = 16'($urandom);
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        wb(0, 8'h00, 0);
        check("slave addr", 32'h01, rd);
        wb(1, 8'h00, 32'h05);
        wb(0, 8'h10, 0);
        check("unmapped", 32'h0, rd);
        for (int i = 0; i < 4; i++) begin
            hreg[i] = 16'($urandom);
            wb(1, 8'h08, i);
            wb(1, 8'h0C, {16'h0000, hreg[i]});
        end
        for (int k = 0; k < 2; k++) begin
            slow <= 1'(k);
            ask(8'h01, 16'h0006, 16'h0007);
            ask(8'h01, 16'h0000, 16'h0020);
            ask(8'h01, 16'h0050, 16'h000C);
            ask(8'h01, 16'h0000, 16'h0021);
            ask(8'h01, 16'h0000, 16'h0000);
            ask(8'h03, 16'h0000, 16'h0004);
            ask(8'h03, 16'h1E00, 16'h0005);
            ask(8'h03, 16'h0000, 16'h0011);
            flags <= 16'($urandom);
            coil_state <= 88'({$urandom, $urandom, $urandom});
            @(posedge core_clk);
        end
        // Broadcast, foreign address, bad CRC, line error and unknown function all stay silent
        for (int k = 0; k < 5; k++) begin
            mbrd_master_model_i.send({k == 0 ? 8'h00 : k == 1 ? 8'h01 : 8'h05,
                                      k == 4 ? 8'h02 : 8'h03, 32'h00000002}, k == 2, k == 3);
            settle;
        end
        ask(8'h03, 16'h0001, 16'h0002);
        wb(0, 8'h04, 0);
        check("status", 32'h00110300, rd);
        wrap_up;
    end
endmodule
